// ==== hdl/sbcgd_clk_div.sv ====
`include "sbcgd_map.svh"
`default_nettype none

// Divider that gives a one-cycle phase enable at four times the serial-bus rate.
module sbcgd_clk_div #(
   parameter int NORM_COUNT = `SBCGD_MCLK_HZ / (`SBCGD_NORMAL_HZ * `SBCGD_PHASES_PER_BIT),
   parameter int TEST_COUNT = `SBCGD_MCLK_HZ / (`SBCGD_TEST_HZ * `SBCGD_PHASES_PER_BIT)
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic testRate,
   output var  logic phaseTick
);

   // Counts must fit the counter and be at least one cycle.
   generate
      if (NORM_COUNT < 1 || TEST_COUNT < 1 || NORM_COUNT > 65535 || TEST_COUNT > 65535) begin : g_chk
         $error("Divider counts out of range.");
      end
   endgenerate

   localparam logic [15:0] NORM_LAST = 16'(NORM_COUNT - 1);   // Last count at normal rate.
   localparam logic [15:0] TEST_LAST = 16'(TEST_COUNT - 1);   // Last count at test rate.

   logic [15:0] count_reg;    // Cycles since the last tick.
   logic [15:0] count_next;   // Next count.
   logic        tick_next;    // Next tick.
   logic        rate_reg;     // Rate in force for the running period.
   logic        rate_next;    // Rate for the next period.

   // The count restarts at every tick. The rate is taken up only at a wrap, so a
   // change of rate never cuts a running period short.
   always_comb begin
      tick_next  = 1'b0;
      rate_next  = rate_reg;
      count_next = count_reg + 16'h0001;
      if (count_reg >= (rate_reg ? TEST_LAST : NORM_LAST)) begin
         count_next = 16'h0000;
         tick_next  = 1'b1;
         rate_next  = testRate;
      end
   end

   // Registers the count and the tick.
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_reg <= 16'h0000;
         rate_reg  <= 1'b0;
         phaseTick <= 1'b0;
      end else begin
         count_reg <= count_next;
         rate_reg  <= rate_next;
         phaseTick <= tick_next;
      end
   end

endmodule // sbcgd_clk_div

`default_nettype wire

// ==== hdl/sbcgd_ctrl.sv ====
`include "sbcgd_map.svh"
`default_nettype none

// Operation
// [R1] Bit 7 chooses address framing, reset 0.
// [R2] Bit 6 reads zero, ignores writes.
// [R3] Bit 5 shows a software cycle running.
// [R4] Bit 4 shows EEPROM default load running.
// [R5] Bit 3 set on detection, software writable.
// [R6] Detection runs once after each reset.
// [R7] Load runs only when EEPROM present.
// [R8] Present bit hands pins 4, 5 to bus.
// [R9] Bit 2 picks 60 kHz or 4 MHz.
// [R10] Bit 1 latches software cycle errors.
// [R11] Bit 0 latches EEPROM load errors.
// [R12] Direction bits: 0 input, 1 output, reset input.
// [R13] Direction ignored on pins serving the bus.
// [R14] Direction bits 15:8 read zero.
// [R15] Slave-address write starts one bus cycle.
// [R16] Command bit picks single write or read.
// [R17] Read byte valid once busy clears. This block captures no read byte; only busy clears.
// [R18] Busy holds until cycle ends, error or not.
module sbcgd_ctrl (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic        cfgWrEn,
   input  wire logic [7:0]  cfgWrData,
   input  wire logic        cfgRdEn,
   output var  logic [7:0]  cfgRdData,
   input  wire logic [7:0]  pinIn,
   output var  logic [7:0]  pinOut,
   output var  logic [7:0]  pinOe,
   input  wire logic [7:0]  gpioOutData,
   output var  logic [7:0]  gpioInData,
   output var  logic        engStart,
   output var  logic        engProbe,
   output var  logic        engLoad,
   output var  logic        engReadCmd,
   output var  logic        engAddrMode,
   output var  logic        engPhaseTick,
   input  wire logic        engDone,
   input  wire logic        engError,
   input  wire logic        engAck,
   input  wire logic        engSclOe,
   input  wire logic        engSdaOe,
   output var  logic        engSclIn,
   output var  logic        engSdaIn
);

   // Configuration write decode, used for every register that takes writes.
   function automatic logic wrHit(input logic [7:0] addr, input logic en, input logic [7:0] off);
      wrHit = en && (addr == off);
   endfunction

   // Pin synchroniser: the first stage is read only by the second.
   logic [7:0] pinMeta_reg;   // First stage.
   logic [7:0] pinSync_reg;   // Second stage, the only one logic reads.

   // Control and status state.
   sbcgd_pkg::sbcgd_state_t state_reg;   // Sequencer state.
   sbcgd_pkg::sbcgd_state_t state_next;  // Next sequencer state.
   logic       addrMode_reg;    // Address framing select.
   logic       addrMode_next;
   logic       swBusy_reg;      // Software cycle in progress.
   logic       swBusy_next;
   logic       loadBusy_reg;    // Default load in progress.
   logic       loadBusy_next;
   logic       present_reg;     // Serial EEPROM present, pins 4 and 5 on the bus.
   logic       present_next;
   logic       clkTest_reg;     // Fast serial clock for test.
   logic       clkTest_next;
   logic       xferErr_reg;     // Sticky software cycle error.
   logic       xferErr_next;
   logic       loadErr_reg;     // Sticky load error.
   logic       loadErr_next;
   logic       detectDone_reg;  // Detection already tried since reset.
   logic       detectDone_next;
   logic [7:0] dir_reg;         // Pin directions.
   logic [7:0] dir_next;
   logic       start_next;      // Next start pulse.
   logic       probe_next;      // Next probe pulse.
   logic       load_next;       // Next load pulse.
   logic       readCmd_next;    // Next cycle type.
   logic [7:0] rd_next;         // Next read data.
   logic [7:0] pinOut_next;     // Next pin levels.
   logic [7:0] pinOe_next;      // Next pin enables.
   logic       ctrlWr;          // Write to the control and status register.
   logic       swReq;           // Write to the slave-address register.
   logic [7:0] statusByte;      // Current control and status value.

   // Phase enable for the serial-bus engine at the selected rate.
   sbcgd_clk_div u_div (
      .mclk      (mclk),
      .rst       (rst),
      .testRate  (clkTest_reg),   // [R9]
      .phaseTick (engPhaseTick)
   );

   // Two flip-flops on every pin before any logic looks at it.
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinMeta_reg <= 8'h00;
         pinSync_reg <= 8'h00;
      end else begin
         pinMeta_reg <= pinIn;
         pinSync_reg <= pinMeta_reg;
      end
   end

   assign ctrlWr = wrHit(cfgAddr, cfgWrEn, `SBCGD_OFF_CTRL_STATUS);
   assign swReq  = wrHit(cfgAddr, cfgWrEn, `SBCGD_OFF_SLAVE_ADDR);   // [R15]

   // Assembles the status byte; the reserved bit is a constant zero.
   always_comb begin
      statusByte = 8'h00;   // [R2]
      statusByte[`SBCGD_BIT_ADDR_MODE] = addrMode_reg;
      statusByte[`SBCGD_BIT_SW_BUSY]   = swBusy_reg;     // [R3]
      statusByte[`SBCGD_BIT_LOAD_BUSY] = loadBusy_reg;   // [R4]
      statusByte[`SBCGD_BIT_PRESENT]   = present_reg;
      statusByte[`SBCGD_BIT_CLK_TEST]  = clkTest_reg;
      statusByte[`SBCGD_BIT_XFER_ERR]  = xferErr_reg;
      statusByte[`SBCGD_BIT_LOAD_ERR]  = loadErr_reg;
   end

   // Register writes, sequencer, error flags and read data.
   always_comb begin
      state_next      = state_reg;
      addrMode_next   = addrMode_reg;
      swBusy_next     = swBusy_reg;
      loadBusy_next   = loadBusy_reg;
      present_next    = present_reg;
      clkTest_next    = clkTest_reg;
      detectDone_next = detectDone_reg;
      dir_next        = dir_reg;
      start_next      = 1'b0;
      probe_next      = 1'b0;
      load_next       = 1'b0;
      readCmd_next    = engReadCmd;
      rd_next         = cfgRdData;
      // Software writes the plain control bits; error bits clear on a written one.
      if (ctrlWr) begin
         addrMode_next = cfgWrData[`SBCGD_BIT_ADDR_MODE];   // [R1]
         present_next  = cfgWrData[`SBCGD_BIT_PRESENT];     // [R5]
         clkTest_next  = cfgWrData[`SBCGD_BIT_CLK_TEST];    // [R9]
      end
      xferErr_next = xferErr_reg & ~(ctrlWr & cfgWrData[`SBCGD_BIT_XFER_ERR]);
      loadErr_next = loadErr_reg & ~(ctrlWr & cfgWrData[`SBCGD_BIT_LOAD_ERR]);
      // Only the low byte of the direction register holds state.
      if (wrHit(cfgAddr, cfgWrEn, `SBCGD_OFF_DIR_LOW)) begin
         dir_next = cfgWrData;   // [R12]
      end
      case (state_reg)
         // Detection goes first, once; later requests are taken only when idle.
         sbcgd_pkg::ST_IDLE: begin
            if (!detectDone_reg) begin
               probe_next      = 1'b1;   // [R6]
               detectDone_next = 1'b1;   // [R6]
               state_next      = sbcgd_pkg::ST_PROBE;
            end else if (swReq) begin
               start_next   = 1'b1;                            // [R15]
               readCmd_next = cfgWrData[`SBCGD_BIT_RW_CMD];    // [R16]
               swBusy_next  = 1'b1;                            // [R3]
               state_next   = sbcgd_pkg::ST_SWCYC;
            end
         end
         // An acknowledged probe marks the EEPROM present and starts the load.
         sbcgd_pkg::ST_PROBE: begin
            if (engDone) begin
               if (engAck) begin
                  present_next  = 1'b1;   // [R5]
                  load_next     = 1'b1;   // [R7]
                  loadBusy_next = 1'b1;   // [R4]
                  state_next    = sbcgd_pkg::ST_LOAD;
               end else begin
                  state_next = sbcgd_pkg::ST_IDLE;   // [R7]
               end
            end
         end
         // Load runs until the engine reports its end.
         sbcgd_pkg::ST_LOAD: begin
            if (engDone) begin
               loadBusy_next = 1'b0;   // [R4]
               state_next    = sbcgd_pkg::ST_IDLE;
            end
         end
         // Busy stays up until the engine ends the cycle, good or bad.
         sbcgd_pkg::ST_SWCYC: begin
            if (engDone) begin
               swBusy_next = 1'b0;   // [R18] [R17]
               state_next  = sbcgd_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next    = sbcgd_pkg::ST_IDLE;
            swBusy_next   = 1'b0;
            loadBusy_next = 1'b0;
         end
      endcase
      // Hardware sets win over a clear in the same cycle.
      if (state_reg == sbcgd_pkg::ST_SWCYC && engDone && engError) begin
         xferErr_next = 1'b1;   // [R10]
      end
      if (state_reg == sbcgd_pkg::ST_LOAD && engDone && engError) begin
         loadErr_next = 1'b1;   // [R11]
      end
      // Read data; unmapped and reserved bytes read as zero.
      if (cfgRdEn) begin
         case (cfgAddr)
            `SBCGD_OFF_CTRL_STATUS: rd_next = statusByte;
            `SBCGD_OFF_DIR_LOW:     rd_next = dir_reg;
            `SBCGD_OFF_DIR_HIGH:    rd_next = 8'h00;   // [R14]
            default:                rd_next = 8'h00;
         endcase
      end
   end

   // Pin drive: bus pins follow the engine as open drain, the rest follow direction.
   always_comb begin
      pinOe_next  = dir_reg;       // [R12]
      pinOut_next = gpioOutData;
      if (present_reg) begin
         pinOe_next[`SBCGD_PIN_SCL]  = engSclOe;   // [R8] [R13]
         pinOe_next[`SBCGD_PIN_SDA]  = engSdaOe;   // [R8] [R13]
         pinOut_next[`SBCGD_PIN_SCL] = 1'b0;
         pinOut_next[`SBCGD_PIN_SDA] = 1'b0;
      end
   end

   // Registers all control state and every output except engPhaseTick, which comes from the divider.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg      <= sbcgd_pkg::ST_IDLE;
         addrMode_reg   <= 1'b0;
         swBusy_reg     <= 1'b0;
         loadBusy_reg   <= 1'b0;
         present_reg    <= 1'b0;
         clkTest_reg    <= 1'b0;
         xferErr_reg    <= 1'b0;
         loadErr_reg    <= 1'b0;
         detectDone_reg <= 1'b0;
         dir_reg        <= `SBCGD_RST_DIR;
         cfgRdData      <= 8'h00;
         pinOut         <= 8'h00;
         pinOe          <= 8'h00;
         gpioInData     <= 8'h00;
         engStart       <= 1'b0;
         engProbe       <= 1'b0;
         engLoad        <= 1'b0;
         engReadCmd     <= 1'b0;
         engAddrMode    <= 1'b0;
         engSclIn       <= 1'b1;
         engSdaIn       <= 1'b1;
      end else begin
         state_reg      <= state_next;
         addrMode_reg   <= addrMode_next;
         swBusy_reg     <= swBusy_next;
         loadBusy_reg   <= loadBusy_next;
         present_reg    <= present_next;
         clkTest_reg    <= clkTest_next;
         xferErr_reg    <= xferErr_next;
         loadErr_reg    <= loadErr_next;
         detectDone_reg <= detectDone_next;
         dir_reg        <= dir_next;
         cfgRdData      <= rd_next;
         pinOut         <= pinOut_next;
         pinOe          <= pinOe_next;
         gpioInData     <= pinSync_reg;
         engStart       <= start_next;
         engProbe       <= probe_next;
         engLoad        <= load_next;
         engReadCmd     <= readCmd_next;
         engAddrMode    <= addrMode_reg;   // [R1]
         engSclIn       <= pinSync_reg[`SBCGD_PIN_SCL];
         engSdaIn       <= pinSync_reg[`SBCGD_PIN_SDA];
      end
   end

endmodule // sbcgd_ctrl

`default_nettype wire

// ==== hdl/sbcgd_map.svh ====
`ifndef SBCGD_MAP_SVH
`define SBCGD_MAP_SVH

// Register offsets in configuration space.
`define SBCGD_OFF_SLAVE_ADDR   8'hB2
`define SBCGD_OFF_CTRL_STATUS  8'hB3
`define SBCGD_OFF_DIR_LOW      8'hB4
`define SBCGD_OFF_DIR_HIGH     8'hB5

// Field positions in the serial-bus control and status register.
`define SBCGD_BIT_ADDR_MODE    7
`define SBCGD_BIT_RESERVED     6
`define SBCGD_BIT_SW_BUSY      5
`define SBCGD_BIT_LOAD_BUSY    4
`define SBCGD_BIT_PRESENT      3
`define SBCGD_BIT_CLK_TEST     2
`define SBCGD_BIT_XFER_ERR     1
`define SBCGD_BIT_LOAD_ERR     0

// Field position of the read/write command in the slave-address register.
`define SBCGD_BIT_RW_CMD       0

// Pins shared with the serial bus.
`define SBCGD_PIN_SCL          4
`define SBCGD_PIN_SDA          5

// Reset values.
`define SBCGD_RST_CTRL_STATUS  8'h00
`define SBCGD_RST_DIR          8'h00

// Timing: core clock and the two serial-bus rates, in hertz.
`define SBCGD_MCLK_HZ          100000000
`define SBCGD_NORMAL_HZ        60000
`define SBCGD_TEST_HZ          4000000
// Serial-bus ticks per bit period (quarter-bit phases).
`define SBCGD_PHASES_PER_BIT   4

`endif

// ==== hdl/sbcgd_pkg.sv ====
`default_nettype none

// Shared types of the serial-bus control and pin direction block.
package sbcgd_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,   // Waiting for detection or a software request.
      ST_PROBE = 4'b0010,   // Looking for a serial EEPROM.
      ST_LOAD  = 4'b0100,   // Loading register defaults.
      ST_SWCYC = 4'b1000    // Running one software-requested cycle.
   } sbcgd_state_t;

   // One configuration byte.
   typedef logic [7:0] sbcgd_byte_t;

endpackage

`default_nettype wire

// ==== test/sbcgd_engine_model.sv ====
`default_nettype none

// Behavioural serial engine; it answers after a set wait, with ack and error taken from ackCfg and errCfg.
module sbcgd_engine_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       engStart,
   input  wire logic       engProbe,
   input  wire logic       engLoad,
   input  wire logic       engPhaseTick,
   input  wire logic       ackCfg,
   input  wire logic       errCfg,
   input  wire logic [7:0] waitCfg,
   output var  logic       engDone,
   output var  logic       engError,
   output var  logic       engAck,
   output var  logic       engSclOe,
   output var  logic       engSdaOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt; // Cycles left in the running job.
   logic       run; // A job is under way.
   // Any request restarts the wait; the answer comes as a one-cycle pulse.
   always @(posedge mclk) begin
      engDone  <= 1'b0;
      engError <= 1'b0;
      engAck   <= 1'b0;
      if (rst) begin
         run <= 1'b0;
      end else if (engStart || engProbe || engLoad) begin
         run <= 1'b1;
         cnt <= waitCfg;
      end else if (run && cnt == 8'h00) begin
         run      <= 1'b0;
         engDone  <= 1'b1;
         engError <= errCfg;
         engAck   <= ackCfg;
      end else if (run) begin
         cnt <= cnt - 8'h01;
      end
      // The lines are only pulled while a job runs, so idle pins stay released.
      engSclOe <= run && !rst && (engPhaseTick ? !engSclOe : engSclOe);
      engSdaOe <= run && !rst && cnt[0];
   end
endmodule // sbcgd_engine_model

`default_nettype wire

// ==== test/sbcgd_sva.sv ====
`default_nettype none

// Port-level checks of the serial-bus control block.
module sbcgd_sva (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [7:0] cfgAddr,
   input wire logic       cfgWrEn,
   input wire logic [7:0] cfgWrData,
   input wire logic       cfgRdEn,
   input wire logic [7:0] cfgRdData,
   input wire logic [7:0] pinOe,
   input wire logic       engStart,
   input wire logic       engProbe,
   input wire logic       engLoad,
   input wire logic       engReadCmd,
   input wire logic       engPhaseTick,
   input wire logic       engDone,
   input wire logic       engAck
);
   timeunit 1ns;
   timeprecision 1ps;
   logic probed_reg;  // Set once detection has been issued since reset.
   logic probed_next; // Next value of the detection flag.
   // Remembers the first probe, so that a second one can be caught.
   always_comb begin
      probed_next = rst ? 1'b0 : (probed_reg | engProbe);
   end
   always_ff @(posedge mclk) begin
      probed_reg <= probed_next;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_rsvd_reads_zero: assert property (cfgRdEn && cfgAddr == 8'hB3 |=> !cfgRdData[6])
      else $error("status bit 6 read back as one");
   a_dir_high_zero: assert property (cfgRdEn && cfgAddr == 8'hB5 |=> cfgRdData == 8'h00)
      else $error("direction high byte not zero");
   a_start_from_write: assert property (engStart |-> $past(cfgWrEn) && $past(cfgAddr) == 8'hB2
      && engReadCmd == $past(cfgWrData[0]))
      else $error("cycle start without matching slave address write");
   a_probe_after_rst: assert property ($fell(rst) |-> ##[1:2] engProbe)
      else $error("no detection probe after reset");
   a_probe_only_once: assert property (engProbe |-> !probed_reg)
      else $error("second detection probe");
   a_load_needs_ack: assert property (engLoad |-> $past(engDone) && $past(engAck))
      else $error("load started without a detected memory");
   a_tick_min_gap: assert property (engPhaseTick |=> !engPhaseTick [*5])
      else $error("phase ticks closer than the test rate");
   a_dir_drives_oe: assert property (cfgWrEn && cfgAddr == 8'hB4 |-> ##2
      (pinOe[7:6] == $past(cfgWrData[7:6], 2) && pinOe[3:0] == $past(cfgWrData[3:0], 2)))
      else $error("pin enable does not follow direction");
endmodule // sbcgd_sva

bind sbcgd_ctrl sbcgd_sva chk_i (.mclk(mclk), .rst(rst), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn),
   .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .pinOe(pinOe),
   .engStart(engStart), .engProbe(engProbe), .engLoad(engLoad), .engReadCmd(engReadCmd),
   .engPhaseTick(engPhaseTick), .engDone(engDone), .engAck(engAck));

`default_nettype wire

// ==== test/test_sbcgd_ctrl.sv ====
`default_nettype none

// Self-checking bench: the driver queues expected read data, a monitor compares.
module test_sbcgd_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, rst = 1, cfgWrEn = 0, cfgRdEn = 0, linkClk = 0, rdSeen = 0;
   logic        ackCfg = 1, errCfg = 0;
   logic [7:0]  cfgAddr = 0, cfgWrData = 0, gpioOutData = 0, ext = 0, r;
   logic [7:0]  cfgRdData, pinOut, pinOe, gpioInData, pinIn;
   logic        engStart, engProbe, engLoad, engReadCmd, engAddrMode, engPhaseTick;
   logic        engDone, engError, engAck, engSclOe, engSdaOe, engSclIn, engSdaIn;
   logic [15:0] expQ[$]; // Mask in the high byte, expected value in the low byte.
   logic [15:0] e;       // Note taken off the queue.
   logic [2:0]  lkHist = 0; // Link clock at the last three rising core edges.
   int          miscompares = 0, n_tests = 0, seed = 32'h374c, n, startCnt = 0, loadCnt = 0;
   always #5 mclk = ~mclk;
   always #80 linkClk = ~linkClk;
   // Driven pins read back their own level; pin 4 otherwise sees the link clock.
   assign pinIn = (pinOe & pinOut) | (~pinOe & {ext[7:5], linkClk, ext[3:0]});
   sbcgd_ctrl uut (.mclk(mclk), .rst(rst), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn),
      .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .gpioOutData(gpioOutData), .gpioInData(gpioInData),
      .engStart(engStart), .engProbe(engProbe), .engLoad(engLoad), .engReadCmd(engReadCmd),
      .engAddrMode(engAddrMode), .engPhaseTick(engPhaseTick), .engDone(engDone),
      .engError(engError), .engAck(engAck), .engSclOe(engSclOe), .engSdaOe(engSdaOe),
      .engSclIn(engSclIn), .engSdaIn(engSdaIn));
   sbcgd_engine_model partner (.mclk(mclk), .rst(rst), .engStart(engStart), .engProbe(engProbe),
      .engLoad(engLoad), .engPhaseTick(engPhaseTick), .ackCfg(ackCfg), .errCfg(errCfg),
      .waitCfg(8'h28), .engDone(engDone), .engError(engError), .engAck(engAck),
      .engSclOe(engSclOe), .engSdaOe(engSdaOe));
   // Read data is due one edge after the read; starts and loads are counted.
   always @(posedge mclk) begin
      if (rdSeen) begin
         e = expQ.pop_front();
         n_tests++;
         if ((cfgRdData & e[15:8]) !== e[7:0]) begin
            miscompares++;
            $display("wrong value at %0t: read %h expected %h", $time, cfgRdData, e[7:0]);
         end
      end
      rdSeen = cfgRdEn;
      lkHist = {lkHist[1:0], linkClk};
      startCnt += engStart;
      loadCnt += engLoad;
   end
   // Direct comparison of a port value.
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle register write; random pin levels change with it.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      cfgAddr = a;
      cfgWrData = d;
      cfgWrEn = 1'b1;
      ext = $random(seed);
      gpioOutData = $random(seed);
      @(negedge mclk);
      cfgWrEn = 1'b0;
   endtask
   // One-cycle register read; the expectation goes on the queue.
   task rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
      @(negedge mclk);
      cfgAddr = a;
      cfgRdEn = 1'b1;
      expQ.push_back({m, x & m});
      @(negedge mclk);
      cfgRdEn = 1'b0;
   endtask
   // Bounded wait for a load start (0), a done (1) or a phase tick (2).
   task waitEv(input int w, output int c);
      c = 0;
      do begin
         @(negedge mclk);
         c++;
      end while (!(w == 0 ? engLoad : (w == 1 ? engDone : engPhaseTick)) && c < 2000);
      if (c >= 2000) begin
         miscompares++;
         $display("wrong value at %0t: wait ran out", $time);
         final_report();
      end
   endtask
   // Holds reset for six cycles.
   task doReset;
      rst = 1'b1;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
   endtask
   // Prints the verdict and stops.
   task final_report;
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      doReset();
      rd(8'hB3, 8'h00, 8'hFF);
      rd(8'hB4, 8'h00, 8'hFF);
      waitEv(0, n);
      errCfg = 1'b1;
      rd(8'hB3, 8'h18, 8'hFF);
      waitEv(1, n);
      errCfg = 1'b0;
      rd(8'hB3, 8'h09, 8'hFF);
      wr(8'hB3, 8'hC9);
      rd(8'hB3, 8'h88, 8'hFF);
      chk({15'h0000, engAddrMode}, 16'h0001);
      // Both commands at both rates; errors only at the test rate.
      for (int i = 0; i < 4; i++) begin
         wr(8'hB3, {5'h01, i[1], 2'b00});
         waitEv(2, n);
         waitEv(2, n);
         chk(n[15:0], i[1] ? 16'h0006 : 16'h01A0);
         errCfg = i[1];
         r = $random(seed);
         wr(8'hB2, {r[7:1], i[0]});
         chk({14'h0000, engStart, engReadCmd}, {14'h0000, 1'b1, i[0]});
         wr(8'hB2, r);
         rd(8'hB3, 8'h20, 8'h20);
         waitEv(1, n);
         rd(8'hB3, {6'h00, i[1], 1'b0}, 8'h22);
         wr(8'hB3, 8'h0A);
      end
      chk(startCnt[15:0], 16'h0004);
      r = $random(seed) | 8'h30;
      wr(8'hB4, r);
      wr(8'hB5, 8'hFF);
      rd(8'hB4, r, 8'hFF);
      rd(8'hB5, 8'h00, 8'hFF);
      chk({8'h00, pinOe}, {8'h00, r & 8'hCF});
      wr(8'hB3, 8'h00);
      repeat (2) @(negedge mclk);
      chk({8'h00, pinOe}, {8'h00, r});
      repeat (2) @(negedge mclk);
      chk({pinOut & r, gpioInData}, {gpioOutData & r, (r & gpioOutData) | (~r & ext)});
      rd(8'hB6, 8'h00, 8'hFF);
      ackCfg = 1'b0;
      doReset();
      repeat (100) @(negedge mclk);
      rd(8'hB3, 8'h00, 8'hFF);
      wr(8'hB3, 8'h08);
      rd(8'hB3, 8'h08, 8'hFF);
      // Released bus pins reach the engine two core edges after they are sampled.
      repeat (60) begin
         @(negedge mclk);
         chk({14'h0000, engSclIn, engSdaIn}, {14'h0000, lkHist[2], ext[5]});
      end
      chk(loadCnt[15:0], 16'h0001);
      final_report();
   end
endmodule // test_sbcgd_ctrl

`default_nettype wire
